// ---- design/scsfm_pkg.sv ----
package scsfm_pkg;

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 16;
  localparam logic [13:0] OSCILLATOR_CONTROL_REGISTER_IDX = 14'h0f86;
  localparam logic [13:0] CLOCK_DIVIDER_REGISTER_IDX = 14'h0f87;
  localparam logic [13:0] STATUS_IDX = 14'h0f88;

  // Unlock keys for the oscillator control register
  localparam logic [7:0] UNLOCK_KEY1 = 8'he7;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h18;

  // Oscillator control register fields
  localparam int INTEN_BIT = 7;
  localparam int XTLEN_BIT = 6;
  localparam int WDTEN_BIT = 5;
  localparam int PRIMARY_FAIL_DETECT_ENABLE_BIT = 4;
  localparam int WATCHDOG_FAIL_DETECT_ENABLE_BIT = 3;
  localparam int FLASH_LOW_POWER_ENABLE_BIT = 2;
  localparam int SCKSEL_MSB = 1;
  localparam logic [7:0] OSCILLATOR_CONTROL_REGISTER_RST = 8'ha0;

  // Clock divider register reset values
  localparam logic [7:0] CLOCK_DIVIDER_REGISTER_RST = 8'h00;
  localparam logic [7:0] CLOCK_DIVIDER_REGISTER_LP_RST = 8'h08;

  // Status register fields
  localparam int ST_PFAIL_BIT = 0;
  localparam int ST_WFAIL_BIT = 1;
  localparam int ST_SRC_LSB = 2;
  localparam int ST_LOCK_LSB = 4;
  localparam int ST_FALLBACK_BIT = 6;
  localparam int ST_WDT_DEAD_BIT = 7;

  // Failure detection timing
  localparam int WDT_NOM_HZ = 10000;
  localparam int PFAIL_HZ = 1000;
  localparam int PFAIL_WDT_TICKS = WDT_NOM_HZ / PFAIL_HZ;
  localparam int WFAIL_SYS_CYCLES = 8000;

  typedef enum logic [1:0] {
    SRC_IPO = 2'b00,
    SRC_XTAL = 2'b01,
    SRC_WDT = 2'b10,
    SRC_RSVD = 2'b11
  } scsfm_src_t;

  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_KEY1 = 2'b01,
    LK_OPEN = 2'b11
  } scsfm_lock_t;

endpackage

// ---- design/scsfm_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface scsfm_tick_if;
  logic src_tick;
  logic restart;
  logic [7:0] div_val;
  logic sys_tick;

  modport sel (output src_tick, output restart, output div_val, input sys_tick);
  modport div (input src_tick, input restart, input div_val, output sys_tick);
endinterface
`default_nettype wire

// ---- design/scsfm_osc_edge.sv ----
`timescale 1ns/100ps
`default_nettype none
module scsfm_osc_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Oscillator sampled as a level
  input wire logic osc_in,
  output logic tick_ff
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Sources faster than half of mclk alias; the crystal must stay below that
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= osc_in;
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      last_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      last_ff <= sync_ff;
      tick_ff <= sync_ff & ~last_ff;
    end
  end
endmodule
`default_nettype wire

// ---- design/scsfm_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
module scsfm_divider (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Source ticks in, divided ticks out
  scsfm_tick_if.div tck
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // Divide value 0 or 1 passes every source tick
  always_comb begin
    nxt_cnt = cnt_ff + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (rst || tck.restart) begin
      cnt_ff <= 8'h00;
      tck.sys_tick <= 1'b0;
    end else if (tck.src_tick) begin
      if (nxt_cnt >= tck.div_val) begin
        cnt_ff <= 8'h00;
        tck.sys_tick <= 1'b1;
      end else begin
        cnt_ff <= nxt_cnt;
        tck.sys_tick <= 1'b0;
      end
    end else begin
      tck.sys_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- design/scsfm_clock_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module scsfm_clock_ctrl #(
  parameter int WFAIL_CYCLES = scsfm_pkg::WFAIL_SYS_CYCLES,
  parameter int PFAIL_TICKS = scsfm_pkg::PFAIL_WDT_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scsfm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // Option bit, low enables flash low power at reset
  input wire logic low_power_divide_option,
  // Oscillator outputs from the analog side
  input wire logic ipo_clk,
  input wire logic xtal_clk,
  input wire logic wdt_clk,
  // Oscillator enables
  output logic ipo_en_ff,
  output logic xtal_en_ff,
  output logic wdt_en_ff,
  // System clock and status
  output logic sys_tick_ff,
  output logic [1:0] clk_src_ff,
  output logic flash_pd_ff,
  output logic sys_exception_ff
);
  localparam int WF_W = 14;
  localparam int PF_W = 8;
  localparam logic [WF_W-1:0] WF_LAST = WF_W'(WFAIL_CYCLES - 1);
  localparam logic [PF_W-1:0] PF_LAST = PF_W'(PFAIL_TICKS - 1);

  if (WFAIL_CYCLES < 2 || WFAIL_CYCLES > 16383) begin : g_bad_wfail
    $error("WFAIL_CYCLES out of range");
  end
  if (PFAIL_TICKS < 2 || PFAIL_TICKS > 255) begin : g_bad_pfail
    $error("PFAIL_TICKS out of range");
  end

  function automatic logic hit(input logic [scsfm_pkg::ADDR_W-1:0] a, input logic [13:0] idx);
    hit = (a[15:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic scsfm_pkg::scsfm_src_t src_of(input logic [1:0] f);
    // Reserved code falls back to the precise oscillator
    if (f == scsfm_pkg::SRC_XTAL) begin
      src_of = scsfm_pkg::SRC_XTAL;
    end else if (f == scsfm_pkg::SRC_WDT) begin
      src_of = scsfm_pkg::SRC_WDT;
    end else begin
      src_of = scsfm_pkg::SRC_IPO;
    end
  endfunction

  scsfm_tick_if tck ();

  logic [2:0] osc_in;
  logic [2:0] osc_tick;
  logic [7:0] ctl_ff;
  logic [7:0] div_ff;
  scsfm_pkg::scsfm_lock_t lock_ff;
  scsfm_pkg::scsfm_src_t act_ff;
  scsfm_pkg::scsfm_src_t want_src;
  logic fallback_ff;
  logic wdt_dead_ff;
  logic pf_flag_ff;
  logic wf_flag_ff;
  logic [PF_W-1:0] pf_cnt_ff;
  logic [WF_W-1:0] wf_cnt_ff;
  logic setup;
  logic done;
  logic wr_ctl;
  logic wr_div;
  logic wr_st;
  logic [7:0] wdata;
  logic switching;
  logic pf_armed;
  logic pfail_evt;
  logic wfail_evt;
  logic wdt_tick;
  logic [7:0] st_val;

  assign osc_in = {wdt_clk, xtal_clk, ipo_clk};

  for (genvar i = 0; i < 3; i++) begin : g_osc
    scsfm_osc_edge u_edge (
      .mclk(mclk),
      .rst(rst),
      .osc_in(osc_in[i]),
      .tick_ff(osc_tick[i])
    );
  end

  scsfm_divider u_div (
    .mclk(mclk),
    .rst(rst),
    .tck(tck)
  );

  assign wdt_tick = osc_tick[scsfm_pkg::SRC_WDT];

  // APB decode; one wait-free access phase
  assign setup = psel & ~penable;
  assign done = psel & penable & pready_ff;
  assign wdata = pwdata[7:0];
  assign wr_ctl = done & pwrite & hit(paddr, scsfm_pkg::OSCILLATOR_CONTROL_REGISTER_IDX);
  assign wr_div = done & pwrite & hit(paddr, scsfm_pkg::CLOCK_DIVIDER_REGISTER_IDX);
  assign wr_st = done & pwrite & hit(paddr, scsfm_pkg::STATUS_IDX);

  assign st_val = {wdt_dead_ff, fallback_ff, lock_ff, act_ff, wf_flag_ff, pf_flag_ff};

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        if (hit(paddr, scsfm_pkg::OSCILLATOR_CONTROL_REGISTER_IDX)) begin
          pslverr_ff <= 1'b0;
          prdata_ff <= {24'h00_0000, ctl_ff};
        end else if (hit(paddr, scsfm_pkg::CLOCK_DIVIDER_REGISTER_IDX)) begin
          pslverr_ff <= 1'b0;
          prdata_ff <= {24'h00_0000, div_ff};
        end else if (hit(paddr, scsfm_pkg::STATUS_IDX)) begin
          pslverr_ff <= 1'b0;
          prdata_ff <= {24'h00_0000, st_val};
        end else begin
          pslverr_ff <= 1'b1;
          prdata_ff <= 32'h0000_0000;
        end
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Unlock sequence; writes elsewhere leave it alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_ff <= scsfm_pkg::LK_LOCKED;
    end else if (wr_ctl) begin
      case (lock_ff)
        scsfm_pkg::LK_LOCKED: begin
          if (wdata == scsfm_pkg::UNLOCK_KEY1) begin
            lock_ff <= scsfm_pkg::LK_KEY1;
          end
        end
        scsfm_pkg::LK_KEY1: begin
          if (wdata == scsfm_pkg::UNLOCK_KEY2) begin
            lock_ff <= scsfm_pkg::LK_OPEN;
          end else if (wdata == scsfm_pkg::UNLOCK_KEY1) begin
            lock_ff <= scsfm_pkg::LK_KEY1;
          end else begin
            lock_ff <= scsfm_pkg::LK_LOCKED;
          end
        end
        default: begin
          lock_ff <= scsfm_pkg::LK_LOCKED;
        end
      endcase
    end
  end

  // Control register; hardware clears of detect enables beat a software write
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_ff <= scsfm_pkg::OSCILLATOR_CONTROL_REGISTER_RST;
      ctl_ff[scsfm_pkg::FLASH_LOW_POWER_ENABLE_BIT] <= ~low_power_divide_option;
    end else begin
      if (wr_ctl && lock_ff == scsfm_pkg::LK_OPEN) begin
        ctl_ff <= wdata;
      end
      if (pfail_evt) begin
        ctl_ff[scsfm_pkg::PRIMARY_FAIL_DETECT_ENABLE_BIT] <= 1'b0;
      end
      if (wfail_evt) begin
        ctl_ff[scsfm_pkg::WATCHDOG_FAIL_DETECT_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_ff <= low_power_divide_option ? scsfm_pkg::CLOCK_DIVIDER_REGISTER_RST
                                        : scsfm_pkg::CLOCK_DIVIDER_REGISTER_LP_RST;
    end else if (wr_div) begin
      div_ff <= wdata;
    end
  end

  // Source selection; forced fallback holds until software rewrites the control register
  always_comb begin
    if (fallback_ff) begin
      want_src = scsfm_pkg::SRC_WDT;
    end else begin
      want_src = src_of(ctl_ff[scsfm_pkg::SCKSEL_MSB -: 2]);
    end
  end

  // Change only right after an edge of the old source, or when it has died
  assign switching = (want_src != act_ff) && (osc_tick[act_ff] || fallback_ff);

  always_ff @(posedge mclk) begin
    if (rst) begin
      act_ff <= scsfm_pkg::SRC_IPO;
      fallback_ff <= 1'b0;
    end else begin
      if (switching) begin
        act_ff <= want_src;
      end
      if (pfail_evt) begin
        fallback_ff <= 1'b1;
      end else if (wr_ctl && lock_ff == scsfm_pkg::LK_OPEN) begin
        fallback_ff <= 1'b0;
      end
    end
  end

  assign tck.src_tick = osc_tick[act_ff] & ~switching;
  assign tck.restart = switching;
  assign tck.div_val = div_ff;

  // Primary check: too many watchdog edges between system clock edges
  assign pf_armed = ctl_ff[scsfm_pkg::PRIMARY_FAIL_DETECT_ENABLE_BIT] && !wdt_dead_ff
                    && act_ff != scsfm_pkg::SRC_WDT && !fallback_ff;
  assign pfail_evt = pf_armed && wdt_tick && !tck.sys_tick && pf_cnt_ff == PF_LAST;

  always_ff @(posedge mclk) begin
    if (rst || !pf_armed || tck.sys_tick) begin
      pf_cnt_ff <= '0;
    end else if (wdt_tick && pf_cnt_ff != PF_LAST) begin
      pf_cnt_ff <= pf_cnt_ff + 1'b1;
    end
  end

  // Watchdog check: count system clocks while waiting for a watchdog edge
  assign wfail_evt = ctl_ff[scsfm_pkg::WATCHDOG_FAIL_DETECT_ENABLE_BIT] && tck.sys_tick && !wdt_tick
                     && wf_cnt_ff == WF_LAST;

  always_ff @(posedge mclk) begin
    if (rst || !ctl_ff[scsfm_pkg::WATCHDOG_FAIL_DETECT_ENABLE_BIT] || wdt_tick) begin
      wf_cnt_ff <= '0;
    end else if (tck.sys_tick && wf_cnt_ff != WF_LAST) begin
      wf_cnt_ff <= wf_cnt_ff + 1'b1;
    end
  end

  // Sticky flags; an event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      pf_flag_ff <= 1'b0;
      wf_flag_ff <= 1'b0;
      wdt_dead_ff <= 1'b0;
    end else begin
      if (pfail_evt) begin
        pf_flag_ff <= 1'b1;
      end else if (wr_st && wdata[scsfm_pkg::ST_PFAIL_BIT]) begin
        pf_flag_ff <= 1'b0;
      end
      if (wfail_evt) begin
        wf_flag_ff <= 1'b1;
        wdt_dead_ff <= 1'b1;
      end else if (wr_st && wdata[scsfm_pkg::ST_WFAIL_BIT]) begin
        wf_flag_ff <= 1'b0;
      end
    end
  end

  // Exception pulse; watchdog failure leaves the source alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      sys_exception_ff <= 1'b0;
    end else begin
      sys_exception_ff <= pfail_evt | wfail_evt;
    end
  end

  // Flash stays up only in the cycle of a source clock edge while flash low power is enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_pd_ff <= 1'b0;
      ipo_en_ff <= 1'b1;
      xtal_en_ff <= 1'b0;
      wdt_en_ff <= 1'b1;
      clk_src_ff <= scsfm_pkg::SRC_IPO;
    end else begin
      flash_pd_ff <= ctl_ff[scsfm_pkg::FLASH_LOW_POWER_ENABLE_BIT] & ~tck.src_tick;
      ipo_en_ff <= ctl_ff[scsfm_pkg::INTEN_BIT];
      xtal_en_ff <= ctl_ff[scsfm_pkg::XTLEN_BIT];
      wdt_en_ff <= ctl_ff[scsfm_pkg::WDTEN_BIT] | fallback_ff;
      clk_src_ff <= act_ff;
    end
  end

  assign sys_tick_ff = tck.sys_tick;
endmodule
`default_nettype wire

// ---- sim/scsfm_clock_ctrl_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module scsfm_clock_ctrl_checker #(
  parameter int WFAIL_CYCLES = scsfm_pkg::WFAIL_SYS_CYCLES,
  parameter int PFAIL_TICKS = scsfm_pkg::PFAIL_WDT_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  // Clock control outputs
  input wire logic ipo_en_ff,
  input wire logic xtal_en_ff,
  input wire logic wdt_en_ff,
  input wire logic sys_tick_ff,
  input wire logic [1:0] clk_src_ff,
  input wire logic sys_exception_ff
);
  default clocking cb @(posedge mclk); endclocking
  AST_RST_SRC: assert property (rst |=> clk_src_ff == 2'b00 && !sys_exception_ff && !sys_tick_ff)
    else $error("source not internal after reset");
  AST_RST_EN: assert property (rst |=> ipo_en_ff && !xtal_en_ff && wdt_en_ff)
    else $error("oscillator enables wrong after reset");
  AST_SRC_LEGAL: assert property (disable iff (rst) clk_src_ff != 2'b11)
    else $error("illegal active source");
  AST_WDT_SRC_ON: assert property (disable iff (rst) clk_src_ff == 2'b10 |-> wdt_en_ff)
    else $error("watchdog source running while disabled");
  AST_EXC_PULSE: assert property (disable iff (rst) sys_exception_ff |=> !sys_exception_ff)
    else $error("exception longer than one cycle");
  AST_READY: assert property (disable iff (rst) psel && !penable |=> pready_ff ##1 !pready_ff)
    else $error("ready not in the single access cycle");
  AST_ERR_DATA: assert property (disable iff (rst) pready_ff && pslverr_ff |-> prdata_ff == 32'h0)
    else $error("error response carries data");
  AST_BYTE_DATA: assert property (disable iff (rst) pready_ff |-> prdata_ff[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule
bind scsfm_clock_ctrl scsfm_clock_ctrl_checker #(
  .WFAIL_CYCLES(WFAIL_CYCLES),
  .PFAIL_TICKS(PFAIL_TICKS)
) scsfm_clock_ctrl_checker_i (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .ipo_en_ff(ipo_en_ff),
  .xtal_en_ff(xtal_en_ff), .wdt_en_ff(wdt_en_ff), .sys_tick_ff(sys_tick_ff),
  .clk_src_ff(clk_src_ff), .sys_exception_ff(sys_exception_ff)
);
`default_nettype wire

// ---- sim/scsfm_osc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module scsfm_osc_model #(
  parameter real HALF_NS = 90.0
) (
  // Enable from the design, stop from the bench
  input wire logic en,
  input wire logic dead,
  // Oscillator output
  output logic osc
);
  initial osc = 1'b0;
  // Stopped core rests low, so no edge is ever seen
  always #(HALF_NS) osc = (en && !dead) ? !osc : 1'b0;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [15:0] CTL = {scsfm_pkg::OSCILLATOR_CONTROL_REGISTER_IDX, 2'b00};
  localparam logic [15:0] DIV = {scsfm_pkg::CLOCK_DIVIDER_REGISTER_IDX, 2'b00};
  localparam logic [15:0] STS = {scsfm_pkg::STATUS_IDX, 2'b00};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic opt = 1'b0;
  logic ipo_dead = 1'b0;
  logic xtal_dead = 1'b0;
  logic wdt_dead = 1'b0;
  logic ipo_clk, xtal_clk, wdt_clk, ipo_en_ff, xtal_en_ff, wdt_en_ff;
  logic pready_ff, pslverr_ff, sys_exception_ff;
  logic sys_tick_ff, flash_pd_ff;
  logic [31:0] prdata_ff;
  logic [1:0] clk_src_ff;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 71446;
  // Count parameters shortened so failures are seen within a short run
  scsfm_clock_ctrl #(.WFAIL_CYCLES(20), .PFAIL_TICKS(3)) scsfm_clock_ctrl_i (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .low_power_divide_option(opt), .ipo_clk(ipo_clk),
    .xtal_clk(xtal_clk), .wdt_clk(wdt_clk), .ipo_en_ff(ipo_en_ff), .xtal_en_ff(xtal_en_ff),
    .wdt_en_ff(wdt_en_ff), .sys_tick_ff(sys_tick_ff), .clk_src_ff(clk_src_ff),
    .flash_pd_ff(flash_pd_ff),
    .sys_exception_ff(sys_exception_ff)
  );
  // Watchdog sped up to 1 MHz to keep the run short
  scsfm_osc_model #(.HALF_NS(90.0)) ipo_osc_i (.en(ipo_en_ff), .dead(ipo_dead), .osc(ipo_clk));
  scsfm_osc_model #(.HALF_NS(50.0)) xtal_osc_i (.en(xtal_en_ff), .dead(xtal_dead), .osc(xtal_clk));
  scsfm_osc_model #(.HALF_NS(500.0)) wdt_osc_i (.en(wdt_en_ff), .dead(wdt_dead), .osc(wdt_clk));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [7:0] ctl_rst(input logic o);
    return scsfm_pkg::OSCILLATOR_CONTROL_REGISTER_RST | (o ? 8'h00 : 8'h04);
  endfunction
  function automatic logic [7:0] div_rst(input logic o);
    return o ? scsfm_pkg::CLOCK_DIVIDER_REGISTER_RST : scsfm_pkg::CLOCK_DIVIDER_REGISTER_LP_RST;
  endfunction
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic ok, input string s);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t %s", $time, s);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 50);
    q = prdata_ff;
    e = pslverr_ff;
    if (n >= 50) cmp(1'b0, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    cmp((q & {24'h0, m}) === {24'h0, x}, "read value");
  endtask
  task automatic uw(input logic [7:0] d);
    wr(CTL, scsfm_pkg::UNLOCK_KEY1);
    wr(CTL, scsfm_pkg::UNLOCK_KEY2);
    wr(CTL, d);
  endtask
  task automatic rs(input logic o);
    rst <= 1'b1;
    opt <= o;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wx(input int lim, output logic seen, output int n);
    seen = 1'b0;
    for (n = 0; n < lim && !seen; n++) begin
      @(posedge mclk);
      seen = (sys_exception_ff === 1'b1);
    end
  endtask
  // Source edges taken straight at the pin, so counts may slip by one at each end
  task automatic tally(input int cyc, output int ns, output int no, output int nf);
    logic last;
    ns = 0;
    no = 0;
    nf = 0;
    last = ipo_clk;
    repeat (cyc) begin
      @(posedge mclk);
      if (sys_tick_ff === 1'b1) ns++;
      if (flash_pd_ff === 1'b0) nf++;
      if (ipo_clk === 1'b1 && last === 1'b0) no++;
      last = ipo_clk;
    end
  endtask
  initial begin
    #(25.0 * 20000);
    n_fail++;
    conclude();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic seen;
    logic [7:0] d;
    int n;
    int ns, no, nf;
    for (int o = 0; o < 2; o++) begin
      rs(o[0]);
      chk(CTL, 8'hff, ctl_rst(o[0]));
      chk(DIV, 8'hff, div_rst(o[0]));
      chk(STS, 8'h3c, 8'h00);
    end
    wr(CTL, 8'hb3);
    chk(CTL, 8'hff, 8'ha0);
    wr(CTL, 8'h18);
    wr(CTL, 8'he7);
    wr(CTL, 8'h5a);
    chk(CTL, 8'hff, 8'ha0);
    wr(CTL, 8'he7);
    chk(DIV, 8'hff, 8'h00);
    wr(CTL, 8'h18);
    chk(STS, 8'h30, 8'h30);
    wr(CTL, 8'ha4);
    chk(CTL, 8'hff, 8'ha4);
    wr(CTL, 8'ha0);
    chk(CTL, 8'hff, 8'ha4);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(DIV, d);
      chk(DIV, 8'hff, d);
      d = $random(seed);
      if (d == scsfm_pkg::UNLOCK_KEY1) d = d ^ 8'h01;
      wr(CTL, d);
      chk(CTL, 8'hff, 8'ha4);
    end
    wr(DIV, 8'h04);
    tally(720, ns, no, nf);
    cmp(ns >= no / 4 - 2 && ns <= no / 4 + 2, "divided rate");
    cmp(nf >= no - 2 && nf <= no + 2, "flash power down");
    wr(DIV, 8'h00);
    apb(1'b0, 16'h0010, 8'h00, q, e);
    cmp(e === 1'b1 && q === 32'h0, "unmapped read");
    uw(8'he4);
    repeat (100) @(posedge mclk);
    uw(8'he5);
    repeat (20) @(posedge mclk);
    cmp(clk_src_ff === 2'b01 && xtal_en_ff === 1'b1, "crystal not active");
    uw(8'hf5);
    xtal_dead <= 1'b1;
    wx(300, seen, n);
    cmp(seen === 1'b1 && n > 40, "primary failure timing");
    // Source register follows the fallback flag two edges after the exception
    repeat (2) @(posedge mclk);
    cmp(clk_src_ff === 2'b10, "no fallback");
    chk(CTL, 8'h10, 8'h00);
    chk(STS, 8'h41, 8'h41);
    rs(1'b1);
    uw(8'ha8);
    // Stop just after an edge so the full count is run
    @(posedge wdt_clk);
    @(posedge mclk);
    wdt_dead <= 1'b1;
    wx(400, seen, n);
    cmp(seen === 1'b1 && n > 100, "watchdog failure timing");
    cmp(clk_src_ff === 2'b00, "source moved on watchdog failure");
    chk(CTL, 8'h08, 8'h00);
    chk(STS, 8'h82, 8'h82);
    uw(8'hb0);
    ipo_dead <= 1'b1;
    wdt_dead <= 1'b0;
    wx(300, seen, n);
    cmp(seen === 1'b0 && clk_src_ff === 2'b00, "primary detect after watchdog loss");
    ipo_dead <= 1'b0;
    rs(1'b1);
    wr(DIV, 8'h08);
    uw(8'hb2);
    repeat (20) @(posedge mclk);
    wx(400, seen, n);
    cmp(seen === 1'b0 && clk_src_ff === 2'b10, "fallback with watchdog source");
    chk(CTL, 8'h10, 8'h10);
    conclude();
  end
endmodule
`default_nettype wire
